// [verilog/spsc_pkg.sv]
/*
  Constants and types shared by the system power state controller.
  Assumes a 100 MHz standby clock feeding every register.
*/
package spsc_pkg;

  // Standby clock rate and press threshold
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned LONG_PRESS_S = 4;
  localparam int unsigned LONG_PRESS_CYC = CLK_HZ * LONG_PRESS_S;

  // Switch debounce time in microseconds, and its cycle count
  localparam int unsigned DEBOUNCE_US  = 10_000;
  localparam int unsigned DEBOUNCE_CYC = (CLK_HZ / 1_000_000) * DEBOUNCE_US;

  // Counter width covering the long press count
  localparam int unsigned CNT_W = 32;

  // Number of fan headers
  localparam int unsigned NUM_FANS = 3;

  // Wake request bit positions after synchronising
  localparam int unsigned WK_LAN  = 0;
  localparam int unsigned WK_RTC  = 1;
  localparam int unsigned WK_USB  = 2;
  localparam int unsigned WK_PCIE = 3;
  localparam int unsigned WK_RING = 4;
  localparam int unsigned WK_N    = 5;

  // OS request bit positions
  localparam int unsigned OS_S3  = 0;
  localparam int unsigned OS_S4  = 1;
  localparam int unsigned OS_OFF = 2;
  localparam int unsigned OS_N   = 3;

  // Strap bit positions; the top bit marks the straps as settled
  localparam int unsigned CFG_LAN_S5  = 0;
  localparam int unsigned CFG_RESTORE = 1;
  localparam int unsigned CFG_LAST_ON = 2;
  localparam int unsigned CFG_VALID   = 3;
  localparam int unsigned CFG_N       = 4;

  // Fan drive levels
  localparam logic [NUM_FANS-1:0] FANS_OFF = 3'h0;
  localparam logic [NUM_FANS-1:0] FANS_ON  = 3'h7;

  // Power states seen by the system
  typedef enum logic [2:0] {
    SPSC_ST_S0,
    SPSC_ST_S3,
    SPSC_ST_S4,
    SPSC_ST_S5,
    SPSC_ST_G3
  } spsc_state_e;

endpackage

// [verilog/spsc_debounce.sv]
/*
  Two-flop synchroniser and debounce filter for one slow pin.
  Assumes the pin is asynchronous to clk and changes rarely.
*/
`timescale 1ns/1ps
module spsc_debounce #(
  parameter int unsigned STABLE_CYC = spsc_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Raw pin and filtered level
  input  wire logic pin_in,
  output logic      level_out
);

  logic [spsc_pkg::CNT_W-1:0] cnt_r;
  logic [spsc_pkg::CNT_W-1:0] cnt_nxt;
  logic                       sync1_r;
  logic                       sync2_r;
  logic                       level_r;
  logic                       level_nxt;

  // Count how long the synchronised level differs from the output
  always_comb begin
    cnt_nxt   = '0;
    level_nxt = level_r;
    if (sync2_r != level_r) begin
      if (cnt_r >= spsc_pkg::CNT_W'(STABLE_CYC - 1)) begin
        level_nxt = sync2_r;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // Synchroniser and filter registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      cnt_r   <= '0;
      level_r <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      cnt_r   <= cnt_nxt;
      level_r <= level_nxt;
    end
  end

  assign level_out = level_r;

endmodule

// [verilog/spsc_ctrl.sv]
/*
  System power state controller: tracks S0/S3/S4/S5, times power
  switch presses, gates wake sources by state, drives the supply
  on request and the fan enables, and restores the last state after
  AC returns.
  Assumes all inputs from pins, clk is the 100 MHz standby clock and
  rst is raised while standby power comes up after an AC failure.
*/
// Notes on behaviour
// - S0: short press sleeps, long forces off
// - Soft off: short press powers on
// - Sleep: short press wakes, long goes off
// - LAN/switch/RTC/PCIe wake in S3-S5; USB S3
// - LAN wake from S5 only when enabled
// - Fans powered in S0
// - Fans off when off or sleeping
// - Each fan tach goes to monitor input
// - Monitor may switch each fan off in S0
// - Power-off command drops non-standby rails
// - AC return restores last state, selectable
// - Ring indication wakes from managed state
// - PCIe wake signal wakes S3/S4/S5
`timescale 1ns/1ps
module spsc_ctrl #(
  parameter int unsigned LONG_CYC     = spsc_pkg::LONG_PRESS_CYC,
  parameter int unsigned DEBOUNCE_CYC = spsc_pkg::DEBOUNCE_CYC
) (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst,
  // Front panel switch, active low pin
  input  wire logic                          pwr_sw_n,
  // Wake sources, active low pins
  input  wire logic                          lan_wake_n,
  input  wire logic                          rtc_alarm_n,
  input  wire logic                          usb_wake_n,
  input  wire logic                          pcie_wake_n,
  input  wire logic                          ring_n,
  // Operating system requests, pins from the chipset
  input  wire logic                          os_sleep_s3,
  input  wire logic                          os_sleep_s4,
  input  wire logic                          os_soft_off,
  // Configuration straps
  input  wire logic                          cfg_lan_s5_en,
  input  wire logic                          cfg_restore_last,
  input  wire logic                          last_state_on,
  // Fan monitor interface
  input  wire logic [spsc_pkg::NUM_FANS-1:0] fan_tach,
  input  wire logic [spsc_pkg::NUM_FANS-1:0] mon_fan_en,
  output logic      [spsc_pkg::NUM_FANS-1:0] mon_tach,
  output logic      [spsc_pkg::NUM_FANS-1:0] fan_pwr,
  // Power supply and state report
  output logic                               ps_on_n,
  output logic                               state_on,
  output logic      [2:0]                    sys_state
);

  spsc_pkg::spsc_state_e st_r;
  spsc_pkg::spsc_state_e st_nxt;

  logic [spsc_pkg::CNT_W-1:0]    press_cnt_r;
  logic [spsc_pkg::CNT_W-1:0]    press_cnt_nxt;
  logic                          sw_prev_r;
  logic                          boot_r;
  logic                          boot_nxt;
  logic [spsc_pkg::WK_N-1:0]     wk_s1_r;
  logic [spsc_pkg::WK_N-1:0]     wk_s2_r;
  logic [spsc_pkg::OS_N-1:0]     os_s1_r;
  logic [spsc_pkg::OS_N-1:0]     os_s2_r;
  logic [spsc_pkg::CFG_N-1:0]    cfg_s1_r;
  logic [spsc_pkg::CFG_N-1:0]    cfg_s2_r;
  logic [spsc_pkg::NUM_FANS-1:0] tach_s1_r;
  logic [spsc_pkg::NUM_FANS-1:0] tach_s2_r;
  logic [spsc_pkg::NUM_FANS-1:0] mon_s1_r;
  logic [spsc_pkg::NUM_FANS-1:0] mon_s2_r;
  logic [spsc_pkg::NUM_FANS-1:0] fan_pwr_r;
  logic [spsc_pkg::NUM_FANS-1:0] fan_pwr_nxt;
  logic                          ps_on_n_r;
  logic                          ps_on_n_nxt;
  logic                          state_on_r;
  logic                          state_on_nxt;
  logic                          sw_level;
  logic                          short_press;
  logic                          long_press;
  logic                          wake_any;

  // Debounced switch, high while pressed
  spsc_debounce #(
    .STABLE_CYC (DEBOUNCE_CYC)
  ) u_sw_db (
    .clk       (clk),
    .rst       (rst),
    .pin_in    (~pwr_sw_n),
    .level_out (sw_level)
  );

  // Sleeping states accept wake sources
  function automatic logic is_sleep(input spsc_pkg::spsc_state_e s);
    is_sleep = (s == spsc_pkg::SPSC_ST_S3) || (s == spsc_pkg::SPSC_ST_S4) ||
               (s == spsc_pkg::SPSC_ST_S5);
  endfunction

  // Press classification; reaching the threshold counts as long
  always_comb begin
    press_cnt_nxt = press_cnt_r;
    short_press   = 1'b0;
    long_press    = 1'b0;
    if (sw_level) begin
      if (press_cnt_r < spsc_pkg::CNT_W'(LONG_CYC)) begin
        press_cnt_nxt = press_cnt_r + 1'b1;
      end
      long_press = sw_prev_r && (press_cnt_r == spsc_pkg::CNT_W'(LONG_CYC - 1));
    end else begin
      press_cnt_nxt = '0;
      short_press   = sw_prev_r && (press_cnt_r < spsc_pkg::CNT_W'(LONG_CYC));
    end
  end

  // Wake gating by state: bits are lan, rtc, usb, pcie, ring
  always_comb begin
    wake_any = 1'b0;
    if (is_sleep(st_r)) begin
      wake_any = wk_s2_r[spsc_pkg::WK_RTC] || wk_s2_r[spsc_pkg::WK_PCIE];
      if (st_r != spsc_pkg::SPSC_ST_S5 || cfg_s2_r[spsc_pkg::CFG_LAN_S5]) begin
        wake_any = wake_any || wk_s2_r[spsc_pkg::WK_LAN];
      end
      if (st_r == spsc_pkg::SPSC_ST_S3) begin
        wake_any = wake_any || wk_s2_r[spsc_pkg::WK_USB] ||
                   wk_s2_r[spsc_pkg::WK_RING];
      end
    end
  end

  // Power state sequencing
  always_comb begin
    st_nxt   = st_r;
    boot_nxt = 1'b0;
    if (boot_r) begin
      // AC restored: wait for settled straps, then restore last state
      boot_nxt = ~cfg_s2_r[spsc_pkg::CFG_VALID];
      if (cfg_s2_r[spsc_pkg::CFG_VALID]) begin
        if (cfg_s2_r[spsc_pkg::CFG_RESTORE] && cfg_s2_r[spsc_pkg::CFG_LAST_ON]) begin
          st_nxt = spsc_pkg::SPSC_ST_S0;
        end else begin
          st_nxt = spsc_pkg::SPSC_ST_S5;
        end
      end
    end else begin
      case (st_r)
        spsc_pkg::SPSC_ST_S0: begin
          if (long_press || os_s2_r[spsc_pkg::OS_OFF]) begin
            st_nxt = spsc_pkg::SPSC_ST_S5;
          end else if (short_press || os_s2_r[spsc_pkg::OS_S3]) begin
            st_nxt = spsc_pkg::SPSC_ST_S3;
          end else if (os_s2_r[spsc_pkg::OS_S4]) begin
            st_nxt = spsc_pkg::SPSC_ST_S4;
          end
        end
        spsc_pkg::SPSC_ST_S3, spsc_pkg::SPSC_ST_S4: begin
          if (long_press) begin
            st_nxt = spsc_pkg::SPSC_ST_S5;
          end else if (short_press || wake_any) begin
            st_nxt = spsc_pkg::SPSC_ST_S0;
          end
        end
        spsc_pkg::SPSC_ST_S5: begin
          if (short_press || wake_any) begin
            st_nxt = spsc_pkg::SPSC_ST_S0;
          end
        end
        spsc_pkg::SPSC_ST_G3: begin
          st_nxt = spsc_pkg::SPSC_ST_S5;
        end
        default: begin
          st_nxt = spsc_pkg::SPSC_ST_S5;
        end
      endcase
    end
  end

  // Fans and supply follow the next state; monitor may switch fans off
  always_comb begin
    fan_pwr_nxt  = spsc_pkg::FANS_OFF;
    ps_on_n_nxt  = 1'b1;
    state_on_nxt = 1'b0;
    if (st_nxt == spsc_pkg::SPSC_ST_S0) begin
      fan_pwr_nxt  = spsc_pkg::FANS_ON & mon_s2_r;
      ps_on_n_nxt  = 1'b0;
      state_on_nxt = 1'b1;
    end
  end

  // State registers, synchronisers and outputs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r        <= spsc_pkg::SPSC_ST_G3;
      boot_r      <= 1'b1;
      press_cnt_r <= '0;
      sw_prev_r   <= 1'b0;
      wk_s1_r     <= '0;
      wk_s2_r     <= '0;
      os_s1_r     <= '0;
      os_s2_r     <= '0;
      cfg_s1_r    <= '0;
      cfg_s2_r    <= '0;
      tach_s1_r   <= '0;
      tach_s2_r   <= '0;
      mon_s1_r    <= '0;
      mon_s2_r    <= '0;
      fan_pwr_r   <= spsc_pkg::FANS_OFF;
      ps_on_n_r   <= 1'b1;
      state_on_r  <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      boot_r      <= boot_nxt;
      press_cnt_r <= press_cnt_nxt;
      sw_prev_r   <= sw_level;
      wk_s1_r     <= ~{ring_n, pcie_wake_n, usb_wake_n, rtc_alarm_n, lan_wake_n};
      wk_s2_r     <= wk_s1_r;
      os_s1_r     <= {os_soft_off, os_sleep_s4, os_sleep_s3};
      os_s2_r     <= os_s1_r;
      cfg_s1_r    <= {1'b1, last_state_on, cfg_restore_last, cfg_lan_s5_en};
      cfg_s2_r    <= cfg_s1_r;
      tach_s1_r   <= fan_tach;
      tach_s2_r   <= tach_s1_r;
      mon_s1_r    <= mon_fan_en;
      mon_s2_r    <= mon_s1_r;
      fan_pwr_r   <= fan_pwr_nxt;
      ps_on_n_r   <= ps_on_n_nxt;
      state_on_r  <= state_on_nxt;
    end
  end

  assign mon_tach  = tach_s2_r;
  assign fan_pwr   = fan_pwr_r;
  assign ps_on_n   = ps_on_n_r;
  assign state_on  = state_on_r;
  assign sys_state = st_r;

endmodule

// [testbench/spsc_ctrl_chk.sv]
/* Port checker for spsc_ctrl.
   Assumes binding into every spsc_ctrl. */
`timescale 1ns/1ps
module spsc_ctrl_chk #(
  parameter int unsigned LONG_CYC     = 50,
  parameter int unsigned DEBOUNCE_CYC = 4
) (
  // Clock, reset, pins
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       pwr_sw_n,
  input wire logic       lan_wake_n,
  input wire logic       rtc_alarm_n,
  input wire logic       pcie_wake_n,
  input wire logic       cfg_lan_s5_en,
  input wire logic       cfg_restore_last,
  input wire logic       last_state_on,
  input wire logic [2:0] fan_tach,
  input wire logic [2:0] mon_fan_en,
  // Outputs
  input wire logic [2:0] mon_tach,
  input wire logic [2:0] fan_pwr,
  input wire logic       ps_on_n,
  input wire logic       state_on,
  input wire logic [2:0] sys_state
);
  localparam int LIM = LONG_CYC + DEBOUNCE_CYC + 8;
  int low_cnt;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Cycles the switch is held
  always_ff @(posedge clk or posedge rst) begin
    if (rst || pwr_sw_n) begin
      low_cnt <= 0;
    end else if (low_cnt < LIM) begin
      low_cnt <= low_cnt + 1;
    end
  end
  a_long_off: assert property (
    low_cnt == LIM && pcie_wake_n && rtc_alarm_n |-> sys_state == 3'h3)
    else $error("long press missed");
  a_restore_last: assert property (
    $fell(rst) |-> ##3 sys_state == (cfg_restore_last && last_state_on ? 3'h0 : 3'h3))
    else $error("bad restore");
  a_fans_off: assert property (sys_state != 3'h0 |-> fan_pwr == 3'h0)
    else $error("fans on");
  a_fan_follow: assert property (
    (sys_state == 3'h0 && $stable(mon_fan_en))[*3] |-> fan_pwr == mon_fan_en)
    else $error("fan drive");
  a_supply_state: assert property (ps_on_n == (sys_state != 3'h0))
    else $error("supply drive");
  a_state_report: assert property (state_on == (sys_state == 3'h0))
    else $error("state report");
  a_tach_route: assert property (
    !$past(rst) && !$past(rst, 2) |-> mon_tach == $past(fan_tach, 2))
    else $error("tach route");
  a_wake_held: assert property (
    (!(pcie_wake_n && rtc_alarm_n) && sys_state inside {3'h1, 3'h2, 3'h3})[*6]
    |=> sys_state == 3'h0)
    else $error("wake missed");
  a_s5_refuse: assert property (
    (sys_state == 3'h3 && (lan_wake_n || !cfg_lan_s5_en) && rtc_alarm_n
     && pcie_wake_n && pwr_sw_n && $past(pwr_sw_n, 8))[*8] |=> sys_state == 3'h3)
    else $error("bad wake");
endmodule
bind spsc_ctrl spsc_ctrl_chk #(.LONG_CYC(LONG_CYC), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (.*);

// [testbench/spsc_partner.sv]
/* Power supply and front panel switch model.
   Assumes ps_on_n comes from the design. */
`timescale 1ns/1ps
module spsc_partner #(
  parameter int DLY = 3,
  parameter int GAP = 12
) (
  // Clock and supply request
  input wire logic clk,
  input wire logic ps_on_n,
  // Rails and switch pin
  output logic     main_ok,
  output logic     pwr_sw_n
);
  int cnt = 0;
  // Main rails rise late, drop at once; standby stays
  always @(posedge clk) cnt <= ps_on_n ? 0 : cnt + 1;
  assign main_ok = !ps_on_n && cnt >= DLY;
  initial pwr_sw_n = 1'b1;
  // Hold switch down n cycles, then leave it up for GAP cycles before returning
  task automatic press(input int n);
    pwr_sw_n = 1'b0;
    repeat (n) @(posedge clk);
    #1 pwr_sw_n = 1'b1;
    repeat (GAP) @(posedge clk);
    #1;
  endtask
endmodule

// [testbench/system_power_state_control_test.sv]
/* Bench for spsc_ctrl with short counts.
   Assumes the partner drives the switch. */
`timescale 1ns/1ps
module system_power_state_control_test;
  localparam int LC = 50;
  logic       clk, rst, pwr_sw_n, ps_on_n, state_on, main_ok;
  logic       lan_wake_n, rtc_alarm_n, usb_wake_n, pcie_wake_n, ring_n;
  logic       os_sleep_s3, os_sleep_s4, os_soft_off;
  logic       cfg_lan_s5_en, cfg_restore_last, last_state_on;
  logic [2:0] fan_tach, mon_fan_en, mon_tach, fan_pwr, sys_state;
  int         err_total = 0;
  int         check_count = 0;
  spsc_ctrl #(.LONG_CYC(LC), .DEBOUNCE_CYC(4)) u_dut (.*);
  spsc_partner u_part (.*);
  // Compare and count
  task automatic chk(input logic [2:0] exp, input logic [2:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: exp %0h got %0h", $time, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Bounded wait for a state
  task automatic go(input logic [2:0] exp);
    for (int i = 0; i < 200 && sys_state !== exp; i++) cyc(1);
    chk(exp, sys_state);
  endtask
  task automatic t_restore(input logic r, input logic l);
    {cfg_restore_last, last_state_on, rst} = {r, l, 1'b1};
    cyc(3);
    rst = 1'b0;
    cyc(4);
    chk((r & l) ? 3'h0 : 3'h3, sys_state);
  endtask
  task automatic t_short;
    chk(3'h6, mon_tach);
    u_part.press(10);
    go(3'h0);
    cyc(4);
    chk(3'h5, fan_pwr);
    chk(3'h1, {2'h0, main_ok});
    u_part.press(10);
    go(3'h1);
    chk(3'h0, fan_pwr);
  endtask
  task automatic t_s3_wake;
    usb_wake_n = 1'b0;
    go(3'h0);
    usb_wake_n = 1'b1;
    u_part.press(10);
    go(3'h1);
    ring_n = 1'b0;
    go(3'h0);
    ring_n = 1'b1;
  endtask
  task automatic t_long;
    u_part.press(LC + 20);
    chk(3'h3, sys_state);
    chk(3'h0, {2'h0, main_ok});
    u_part.press(10);
    go(3'h0);
    u_part.press(10);
    go(3'h1);
    u_part.press(LC + 20);
    chk(3'h3, sys_state);
  endtask
  task automatic t_s5_gate;
    {usb_wake_n, lan_wake_n} = 2'h0;
    cyc(20);
    chk(3'h3, sys_state);
    cfg_lan_s5_en = 1'b1;
    go(3'h0);
    {usb_wake_n, lan_wake_n} = 2'h3;
  endtask
  task automatic t_other;
    u_part.press(LC + 20);
    chk(3'h3, sys_state);
    pcie_wake_n = 1'b0;
    go(3'h0);
    pcie_wake_n = 1'b1;
    cyc(4);
    os_sleep_s4 = 1'b1;
    go(3'h2);
    os_sleep_s4 = 1'b0;
    rtc_alarm_n = 1'b0;
    go(3'h0);
    rtc_alarm_n = 1'b1;
  endtask
  task automatic t_os;
    {fan_tach, mon_fan_en} = 6'h0B;
    cyc(4);
    chk(3'h1, mon_tach);
    chk(3'h3, fan_pwr);
    chk(3'h1, {2'h0, state_on});
    os_sleep_s3 = 1'b1;
    go(3'h1);
    chk(3'h0, fan_pwr);
    os_sleep_s3 = 1'b0;
    rtc_alarm_n = 1'b0;
    go(3'h0);
    rtc_alarm_n = 1'b1;
    cyc(4);
    {os_sleep_s3, os_soft_off} = 2'h3;
    go(3'h3);
    chk(3'h0, {2'h0, state_on});
    {os_sleep_s3, os_soft_off} = 2'h0;
  endtask
  task automatic report_and_stop;
    if (err_total == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Watchdog
  initial begin
    #100000;
    err_total++;
    report_and_stop();
  end
  // Main sequence
  initial begin
    {lan_wake_n, rtc_alarm_n, usb_wake_n, pcie_wake_n, ring_n} = 5'h1F;
    {os_sleep_s3, os_sleep_s4, os_soft_off, cfg_lan_s5_en} = 4'h0;
    {fan_tach, mon_fan_en} = 6'h35;
    t_restore(1'b0, 1'b1);
    t_restore(1'b1, 1'b1);
    t_restore(1'b1, 1'b0);
    t_short();
    t_s3_wake();
    t_long();
    t_s5_gate();
    t_other();
    t_os();
    report_and_stop();
  end
endmodule
